// [include/mcmr_defines.svh]
// Offsets, field positions, reset values and codes of the correction-matrix register bank.
`ifndef MCMR_DEFINES_SVH
`define MCMR_DEFINES_SVH

`define MCMR_ADDR_W 8
`define MCMR_DATA_W 32
`define MCMR_NUM_COEF 7
`define MCMR_NUM_ACCEL 4
`define MCMR_NUM_RATE 3

`define MCMR_OFS_PAGE_SELECT 8'h00
`define MCMR_OFS_CALIB_SELECT 8'h04
`define MCMR_OFS_ACCEL_R2C3 8'h6C
`define MCMR_OFS_ACCEL_R3C1 8'h70
`define MCMR_OFS_ACCEL_R3C2 8'h74
`define MCMR_OFS_ACCEL_R3C3 8'h78
`define MCMR_OFS_RATE_R1C1 8'h7C
`define MCMR_OFS_RATE_R1C2 8'h80
`define MCMR_OFS_RATE_R1C3 8'h84

`define MCMR_FLOAT_ONE 32'h3F80_0000
`define MCMR_FLOAT_ZERO 32'h0000_0000
`define MCMR_RST_ACCEL_R2C3 `MCMR_FLOAT_ZERO
`define MCMR_RST_ACCEL_R3C1 `MCMR_FLOAT_ZERO
`define MCMR_RST_ACCEL_R3C2 `MCMR_FLOAT_ZERO
`define MCMR_RST_ACCEL_R3C3 `MCMR_FLOAT_ONE
`define MCMR_RST_RATE_R1C1 `MCMR_FLOAT_ONE
`define MCMR_RST_RATE_R1C2 `MCMR_FLOAT_ZERO
`define MCMR_RST_RATE_R1C3 `MCMR_FLOAT_ZERO

`define MCMR_RST_PAGE 8'h00
`define MCMR_COEF_PAGE 8'h00
`define MCMR_RST_CALIB 2'h0
`define MCMR_CALIB_ACCEL_BIT 0
`define MCMR_CALIB_RATE_BIT 1

`define MCMR_RESP_OKAY 2'h0
`define MCMR_RESP_SLVERR 2'h2

`endif

// [include/mcmr_pkg.sv]
// Types shared by the correction-matrix register bank modules.
`include "mcmr_defines.svh"

package mcmr_pkg;

    typedef struct packed {
        logic [`MCMR_NUM_ACCEL-1:0][`MCMR_DATA_W-1:0] accel;
        logic [`MCMR_NUM_RATE-1:0][`MCMR_DATA_W-1:0] rate;
    } mcmr_coef_t;

    typedef struct packed {
        logic [`MCMR_DATA_W-1:0] value;
    } mcmr_cell_state_t;

    typedef struct packed {
        logic aw_full;
        logic w_full;
        logic awready;
        logic wready;
        logic [`MCMR_ADDR_W-1:0] addr;
        logic [`MCMR_DATA_W-1:0] data;
        logic [3:0] strb;
    } mcmr_wc_state_t;

    typedef struct packed {
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [`MCMR_DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic [7:0] page;
        logic [1:0] calib;
        mcmr_coef_t applied;
    } mcmr_state_t;

endpackage

// [src/mcmr_wr_collect.sv]
// Holds one AXI4-Lite write address and one write data beat until the bank consumes them.
`include "mcmr_defines.svh"

module mcmr_wr_collect (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [`MCMR_ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [`MCMR_DATA_W-1:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic i_consume,
    output logic o_valid,
    output logic [`MCMR_ADDR_W-1:0] o_addr,
    output logic [`MCMR_DATA_W-1:0] o_data,
    output logic [3:0] o_strb
);

    mcmr_pkg::mcmr_wc_state_t st_reg;
    mcmr_pkg::mcmr_wc_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (i_awvalid && st_reg.awready) begin
            st_next.aw_full = 1'b1;
            st_next.addr = i_awaddr;
        end
        if (i_wvalid && st_reg.wready) begin
            st_next.w_full = 1'b1;
            st_next.data = i_wdata;
            st_next.strb = i_wstrb;
        end
        // Consume is only raised while both halves are held, so no new beat can be taken in that cycle.
        if (i_consume) begin
            st_next.aw_full = 1'b0;
            st_next.w_full = 1'b0;
        end
        st_next.awready = ~st_next.aw_full;
        st_next.wready = ~st_next.w_full;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_awready = st_reg.awready;
    assign o_wready = st_reg.wready;
    assign o_valid = st_reg.aw_full & st_reg.w_full;
    assign o_addr = st_reg.addr;
    assign o_data = st_reg.data;
    assign o_strb = st_reg.strb;

endmodule

// [src/mcmr_coef_cell.sv]
// One 32-bit floating-point coefficient stored with bus byte lanes mapped most significant byte first.
`include "mcmr_defines.svh"

module mcmr_coef_cell #(
    parameter logic [`MCMR_DATA_W-1:0] RESET_VALUE = 32'h0000_0000
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_write,
    input wire logic [3:0] i_wstrb,
    input wire logic [`MCMR_DATA_W-1:0] i_wdata,
    input wire logic i_load,
    input wire logic [`MCMR_DATA_W-1:0] i_load_value,
    output logic [`MCMR_DATA_W-1:0] o_value
);

    mcmr_pkg::mcmr_cell_state_t st_reg;
    mcmr_pkg::mcmr_cell_state_t st_next;
    logic [3:0][7:0] byte_next;

    // Lane k of the bus is address offset k, which holds value bits 31-8k down to 24-8k.
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_lane
            assign byte_next[3-k] = (i_write && i_wstrb[k]) ? i_wdata[8*k +: 8] :
                                    (i_load ? i_load_value[8*(3-k) +: 8] : st_reg.value[8*(3-k) +: 8]);
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        st_next.value = byte_next;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg.value <= RESET_VALUE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_value = st_reg.value;

endmodule

// [src/mcmr_top.sv]
// AXI4-Lite register bank for the lower accelerometer and first-row rate correction-matrix coefficients.
//
// Summary of operation
// - Rate matrix is applied only while rate calibration select is set.
// - Each coefficient is one 3x3 matrix element spanning four byte addresses.
// - The four bytes form one IEEE single-precision float value.
// - Lowest address holds bits 31:24, next address bits 23:16.
// - Third address holds bits 15:8, highest address bits 7:0.
// - Every coefficient byte is readable and writable; reads return the last write or restore load.
// - Coefficients can be backed up and restored from flash image port.
// - Reset values form the identity matrix: one on diagonal, zero elsewhere.
// - Coefficients are reachable only while register page zero is selected.
// - Accel elements 2,3 3,1 3,2 3,3 sit at 0x6C through 0x78.
// - Rate elements 1,1 1,2 1,3 sit at 0x7C through 0x87.
// - Accel matrix is applied only while accel calibration select is set.
`include "mcmr_defines.svh"

module mcmr_top (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [`MCMR_ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [`MCMR_DATA_W-1:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [`MCMR_ADDR_W-1:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [`MCMR_DATA_W-1:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic i_restore_load,
    input wire mcmr_pkg::mcmr_coef_t i_restore_image,
    output mcmr_pkg::mcmr_coef_t o_backup_image,
    output mcmr_pkg::mcmr_coef_t o_applied_matrix,
    output logic [1:0] o_external_calibration_select,
    output logic [7:0] o_page_select
);

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Address map and reset values.

    localparam logic [`MCMR_NUM_COEF-1:0][`MCMR_ADDR_W-1:0] COEF_OFS = {
        `MCMR_OFS_RATE_R1C3, `MCMR_OFS_RATE_R1C2, `MCMR_OFS_RATE_R1C1,
        `MCMR_OFS_ACCEL_R3C3, `MCMR_OFS_ACCEL_R3C2, `MCMR_OFS_ACCEL_R3C1, `MCMR_OFS_ACCEL_R2C3
    };
    localparam logic [`MCMR_NUM_COEF-1:0][`MCMR_DATA_W-1:0] COEF_RST = {
        `MCMR_RST_RATE_R1C3, `MCMR_RST_RATE_R1C2, `MCMR_RST_RATE_R1C1,
        `MCMR_RST_ACCEL_R3C3, `MCMR_RST_ACCEL_R3C2, `MCMR_RST_ACCEL_R3C1, `MCMR_RST_ACCEL_R2C3
    };
    localparam logic [3:0] NO_SLOT = 4'hF;

    // Returns the coefficient slot that an aligned word address selects, or NO_SLOT.
    function automatic logic [3:0] coef_slot(input logic [`MCMR_ADDR_W-1:0] addr);
        logic [3:0] slot;
        slot = NO_SLOT;
        for (int i = 0; i < `MCMR_NUM_COEF; i++) begin
            if ({addr[`MCMR_ADDR_W-1:2], 2'b00} == COEF_OFS[i]) begin
                slot = 4'(i);
            end
        end
        return slot;
    endfunction

    // Puts the byte at the lowest address onto bus lane 0.
    function automatic logic [`MCMR_DATA_W-1:0] to_lanes(input logic [`MCMR_DATA_W-1:0] value);
        return {value[7:0], value[15:8], value[23:16], value[31:24]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Write channel capture.

    mcmr_pkg::mcmr_state_t st_reg;
    mcmr_pkg::mcmr_state_t st_next;
    logic wc_valid;
    logic [`MCMR_ADDR_W-1:0] wc_addr;
    logic [`MCMR_DATA_W-1:0] wc_data;
    logic [3:0] wc_strb;
    logic wr_take;
    logic [3:0] wr_slot;
    logic [3:0] rd_slot;
    logic page_is_coef;
    logic [`MCMR_NUM_COEF-1:0] coef_we;
    logic [`MCMR_NUM_COEF-1:0][`MCMR_DATA_W-1:0] coef_val;

    mcmr_wr_collect u_wr_collect (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_awaddr(i_s_axi_awaddr),
        .i_awvalid(i_s_axi_awvalid),
        .o_awready(o_s_axi_awready),
        .i_wdata(i_s_axi_wdata),
        .i_wstrb(i_s_axi_wstrb),
        .i_wvalid(i_s_axi_wvalid),
        .o_wready(o_s_axi_wready),
        .i_consume(wr_take),
        .o_valid(wc_valid),
        .o_addr(wc_addr),
        .o_data(wc_data),
        .o_strb(wc_strb)
    );

    // A held write is executed only once the previous response has left, so one response is ever pending.
    assign wr_take = wc_valid & ~st_reg.bvalid;
    assign wr_slot = coef_slot(wc_addr);
    assign rd_slot = coef_slot(i_s_axi_araddr);
    assign page_is_coef = (st_reg.page == `MCMR_COEF_PAGE);

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Coefficient storage.

    genvar g;
    generate
        for (g = 0; g < `MCMR_NUM_COEF; g = g + 1) begin : g_coef
            assign coef_we[g] = wr_take && page_is_coef && (wr_slot == 4'(g));
            mcmr_coef_cell #(
                .RESET_VALUE(COEF_RST[g])
            ) u_cell (
                .i_core_clk(i_core_clk),
                .i_nrst(i_nrst),
                .i_write(coef_we[g]),
                .i_wstrb(wc_strb),
                .i_wdata(wc_data),
                .i_load(i_restore_load),
                .i_load_value(i_restore_image[`MCMR_DATA_W*g +: `MCMR_DATA_W]),
                .o_value(coef_val[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Bus responses, control registers and applied matrix.

    always_comb begin
        st_next = st_reg;

        if (st_reg.bvalid && i_s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (wr_take) begin
            st_next.bvalid = 1'b1;
            st_next.bresp = `MCMR_RESP_SLVERR;
            if ({wc_addr[`MCMR_ADDR_W-1:2], 2'b00} == `MCMR_OFS_PAGE_SELECT) begin
                st_next.bresp = `MCMR_RESP_OKAY;
                if (wc_strb[0]) begin
                    st_next.page = wc_data[7:0];
                end
            end else if ({wc_addr[`MCMR_ADDR_W-1:2], 2'b00} == `MCMR_OFS_CALIB_SELECT) begin
                st_next.bresp = `MCMR_RESP_OKAY;
                if (wc_strb[0]) begin
                    st_next.calib = wc_data[1:0];
                end
            end else if (page_is_coef && wr_slot != NO_SLOT) begin
                st_next.bresp = `MCMR_RESP_OKAY;
            end
        end

        if (st_reg.rvalid && i_s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (i_s_axi_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = '0;
            st_next.rresp = `MCMR_RESP_SLVERR;
            if ({i_s_axi_araddr[`MCMR_ADDR_W-1:2], 2'b00} == `MCMR_OFS_PAGE_SELECT) begin
                st_next.rresp = `MCMR_RESP_OKAY;
                st_next.rdata = {24'h00_0000, st_reg.page};
            end else if ({i_s_axi_araddr[`MCMR_ADDR_W-1:2], 2'b00} == `MCMR_OFS_CALIB_SELECT) begin
                st_next.rresp = `MCMR_RESP_OKAY;
                st_next.rdata = {30'h0000_0000, st_reg.calib};
            end else if (page_is_coef && rd_slot != NO_SLOT) begin
                st_next.rresp = `MCMR_RESP_OKAY;
                st_next.rdata = to_lanes(coef_val[rd_slot[2:0]]);
            end
        end
        // Address is refused while a read answer waits, so only one read is ever under way.
        st_next.arready = ~st_next.rvalid;

        // The element order inside each vector keeps row-major order, so the arithmetic that
        // multiplies the sample vector reads row as first index and column as second.
        for (int i = 0; i < `MCMR_NUM_ACCEL; i++) begin
            st_next.applied.accel[i] = st_reg.calib[`MCMR_CALIB_ACCEL_BIT] ? coef_val[i] : COEF_RST[i];
        end
        for (int i = 0; i < `MCMR_NUM_RATE; i++) begin
            st_next.applied.rate[i] = st_reg.calib[`MCMR_CALIB_RATE_BIT] ?
                                      coef_val[`MCMR_NUM_ACCEL+i] : COEF_RST[`MCMR_NUM_ACCEL+i];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg.bvalid <= 1'b0;
            st_reg.bresp <= `MCMR_RESP_OKAY;
            st_reg.arready <= 1'b0;
            st_reg.rvalid <= 1'b0;
            st_reg.rdata <= '0;
            st_reg.rresp <= `MCMR_RESP_OKAY;
            st_reg.page <= `MCMR_RST_PAGE;
            st_reg.calib <= `MCMR_RST_CALIB;
            // The reset table is in slot order while the struct packs accel high, so load each vector by slice.
            st_reg.applied.accel <= COEF_RST[`MCMR_NUM_ACCEL-1:0];
            st_reg.applied.rate <= COEF_RST[`MCMR_NUM_COEF-1:`MCMR_NUM_ACCEL];
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign o_s_axi_bvalid = st_reg.bvalid;
    assign o_s_axi_bresp = st_reg.bresp;
    assign o_s_axi_arready = st_reg.arready;
    assign o_s_axi_rvalid = st_reg.rvalid;
    assign o_s_axi_rdata = st_reg.rdata;
    assign o_s_axi_rresp = st_reg.rresp;
    assign o_backup_image = coef_val;
    assign o_applied_matrix = st_reg.applied;
    assign o_external_calibration_select = st_reg.calib;
    assign o_page_select = st_reg.page;

endmodule

// [verif/mcmr_top_sva.sv]
// Concurrent checks on the ports of the correction-matrix register bank.
`include "mcmr_defines.svh"

module mcmr_top_chk (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic [1:0] o_s_axi_bresp,
    input wire logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [`MCMR_ADDR_W-1:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic [`MCMR_DATA_W-1:0] o_s_axi_rdata,
    input wire logic [1:0] o_s_axi_rresp,
    input wire logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire mcmr_pkg::mcmr_coef_t o_backup_image,
    input wire mcmr_pkg::mcmr_coef_t o_applied_matrix,
    input wire logic [1:0] o_external_calibration_select,
    input wire logic [7:0] o_page_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    logic coef_rd;
    // Word reads inside the coefficient span; the low address bits are ignored by the bank.
    assign coef_rd = i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr >= 8'h6C && i_s_axi_araddr <= 8'h87;
    ////////////////////////////////////////////////////////////////////////////
    a_b_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response dropped early");
    a_r_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data dropped early");
    a_read_latency: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read answer late");
    a_ar_busy: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("address accepted while data pending");
    a_write_latency: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
        && !o_s_axi_bvalid |=> ##1 o_s_axi_bvalid) else $error("write answer late");
    a_page_block: assert property (coef_rd && o_page_select != 8'h00 |=> o_s_axi_rresp == 2'h2
        && o_s_axi_rdata == 32'h0) else $error("coefficient visible off page");
    a_page_open: assert property (coef_rd && o_page_select == 8'h00 |=> o_s_axi_rresp == 2'h0)
        else $error("coefficient refused on page");
    a_accel_off: assert property (!o_external_calibration_select[0] |=> o_applied_matrix.accel ==
        {32'h3F80_0000, 32'h0, 32'h0, 32'h0}) else $error("accel matrix applied while off");
    a_rate_off: assert property (!o_external_calibration_select[1] |=> o_applied_matrix.rate ==
        {32'h0, 32'h0, 32'h3F80_0000}) else $error("rate matrix applied while off");
    a_accel_on: assert property (o_external_calibration_select[0] |=>
        o_applied_matrix.accel[0] == $past(o_backup_image[31:0])) else $error("accel matrix not applied");
    a_rate_on: assert property (o_external_calibration_select[1] |=>
        o_applied_matrix.rate[0] == $past(o_backup_image[159:128])) else $error("rate matrix not applied");
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the correction-matrix register bank.
`include "mcmr_defines.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0, rld = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, page;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [223:0] img = '0, backup;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, calib;
    mcmr_pkg::mcmr_coef_t applied;
    int errors = 0;
    int checked = 0;

    mcmr_top dut_u (.i_core_clk(clk), .i_nrst(nrst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wv),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_restore_load(rld),
        .i_restore_image(img), .o_backup_image(backup), .o_applied_matrix(applied),
        .o_external_calibration_select(calib), .o_page_select(page));

    initial begin
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // The bus presents word data lane 0 first, so a float reads with its bytes reversed.
    function automatic logic [31:0] lanes(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction
    function automatic logic [31:0] val(input int g);
        return {8'h40 + 8'(g), 8'h11, 8'h22 + 8'(g), 8'h33};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Ready is raised only once the answer shows, so the slave must hold it meanwhile.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        int n;
        tb = 1'h0;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awv <= 1'h1;
        wv <= 1'h1;
        while (!tb && n < 50) begin
            @(negedge clk);
            ta = awv && awready;
            tw = wv && wready;
            tb = bvalid && bready;
            r = bresp;
            n++;
            @(posedge clk);
            if (ta) awv <= 1'h0;
            if (tw) wv <= 1'h0;
            bready <= bvalid && !tb;
        end
        cmp({31'h0, tb}, 32'h1, "write answer");
        cmp({30'h0, r}, {30'h0, er}, "bresp");
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        tr = 1'h0;
        n = 0;
        araddr <= a;
        arv <= 1'h1;
        while (!tr && n < 50) begin
            @(negedge clk);
            ta = arv && arready;
            tr = rvalid && rready;
            d = rdata;
            r = rresp;
            n++;
            @(posedge clk);
            if (ta) arv <= 1'h0;
            rready <= rvalid && !tr;
        end
        cmp({31'h0, tr}, 32'h1, "read answer");
        cmp(d, ed, "rdata");
        cmp({30'h0, r}, {30'h0, er}, "rresp");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_reset;
        for (int g = 0; g < 7; g++) begin
            axi_rd(8'h6C + 8'(4 * g), lanes((g == 3 || g == 4) ? 32'h3F80_0000 : 32'h0), 2'h0);
        end
        cmp({24'h0, page}, 32'h0, "page");
        cmp({30'h0, calib}, 32'h0, "calib");
    endtask
    task automatic s_rw;
        for (int g = 0; g < 7; g++) begin
            axi_wr(8'h6C + 8'(4 * g), lanes(val(g)), 4'hF, 2'h0);
        end
        for (int g = 0; g < 7; g++) begin
            axi_rd(8'h6C + 8'(4 * g), lanes(val(g)), 2'h0);
            cmp(backup[32 * g +: 32], val(g), "backup");
        end
        axi_wr(8'h7C, 32'h0000_00C1, 4'h1, 2'h0);
        axi_wr(8'h7C, 32'h5A00_0000, 4'h8, 2'h0);
        axi_rd(8'h7C, lanes(32'hC111_265A), 2'h0);
        axi_wr(8'h88, 32'h1234_5678, 4'hF, 2'h2);
        axi_rd(8'h68, 32'h0, 2'h2);
    endtask
    task automatic s_page;
        axi_wr(8'h00, 32'h0000_0001, 4'h1, 2'h0);
        cmp({24'h0, page}, 32'h1, "page");
        axi_wr(8'h6C, 32'hFFFF_FFFF, 4'hF, 2'h2);
        axi_rd(8'h84, 32'h0, 2'h2);
        axi_wr(8'h00, 32'h0, 4'h1, 2'h0);
        axi_rd(8'h6C, lanes(val(0)), 2'h0);
    endtask
    task automatic s_calib;
        @(negedge clk);
        cmp(applied.accel[0], 32'h0, "accel off");
        cmp(applied.rate[0], 32'h3F80_0000, "rate off");
        @(posedge clk);
        axi_wr(8'h04, 32'h0000_0003, 4'h1, 2'h0);
        @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            cmp(applied.accel[i], val(i), "accel on");
        end
        for (int i = 0; i < 3; i++) begin
            cmp(applied.rate[i], (i == 0) ? 32'hC111_265A : val(4 + i), "rate on");
        end
        @(posedge clk);
        axi_wr(8'h04, 32'h0000_0002, 4'h1, 2'h0);
        @(negedge clk);
        cmp(applied.accel[3], 32'h3F80_0000, "accel off again");
        cmp(applied.rate[1], val(5), "rate still on");
        @(posedge clk);
    endtask
    task automatic s_restore;
        logic [223:0] im;
        for (int g = 0; g < 7; g++) begin
            im[32 * g +: 32] = {8'hA0, 8'(g), 16'h5AA5};
        end
        img <= im;
        rld <= 1'h1;
        @(posedge clk);
        rld <= 1'h0;
        @(negedge clk);
        cmp(backup[31:0], im[31:0], "restored");
        @(posedge clk);
        for (int g = 0; g < 7; g++) begin
            axi_rd(8'h6C + 8'(4 * g), lanes(im[32 * g +: 32]), 2'h0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        s_reset();
        s_rw();
        s_page();
        s_calib();
        s_restore();
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        cmp(applied.accel[3], 32'h3F80_0000, "applied accel r3c3 in reset");
        cmp(applied.rate[0], 32'h3F80_0000, "applied rate r1c1 in reset");
        cmp(applied.accel[0], 32'h0, "applied accel r2c3 in reset");
        nrst <= 1'h1;
        @(posedge clk);
        s_reset();
        test_done();
    end
endmodule

bind mcmr_top mcmr_top_chk chk_u (.*);
